// ==== hw/rppme_defines.vh ====
// Register offsets, field positions and reset values for root port event reporting
`ifndef RPPME_DEFINES_VH
`define RPPME_DEFINES_VH

`define RPPME_ADDR_W          12
`define RPPME_OFF_ROOT_CTRL   12'h0BC
`define RPPME_OFF_ROOT_STAT   12'h0C0
`define RPPME_CTRL_W          4
`define RPPME_CTRL_RST        4'h0
`define RPPME_BIT_CORR_EN     0
`define RPPME_BIT_NONFATAL_EN 1
`define RPPME_BIT_FATAL_EN    2
`define RPPME_BIT_PME_IE      3
`define RPPME_BIT_PME_STAT    16
`define RPPME_BIT_PME_PEND    17
`define RPPME_RID_W           16
`define RPPME_RID_RST         16'h0000
`define RPPME_QDEPTH          4
`define RPPME_QPTR_W          2
`define RPPME_BE_CTRL         0
`define RPPME_BE_STAT         2
`define RPPME_ERR_N           3
`define RPPME_RDATA_IDLE      32'h00000000

`endif

// ==== hw/rppme_root_port_events.v ====
// Root port error-to-system-error gating and PME status, pending queue and interrupt
`timescale 1ns/1ps
`include "rppme_defines.vh"

module rppme_root_port_events #(
	parameter QDEPTH = `RPPME_QDEPTH,
	parameter QPTR_W = `RPPME_QPTR_W
) (
	// Clock and reset
	input  wire                       clk_sys,
	input  wire                       rst_n,
	// Configuration access
	input  wire                       cfg_wr,
	input  wire                       cfg_rd,
	input  wire [`RPPME_ADDR_W-1:0]   cfg_addr,
	input  wire [31:0]                cfg_wdata,
	input  wire [3:0]                 cfg_be,
	output reg  [31:0]                cfg_rdata,
	// Error sources, local and from link; cmd_serr_en is not used
	input  wire                       loc_err_fatal,
	input  wire                       loc_err_nonfatal,
	input  wire                       loc_err_corr,
	input  wire                       msg_err_fatal,
	input  wire                       msg_err_nonfatal,
	input  wire                       msg_err_corr,
	input  wire                       cmd_serr_en,
	// PME message from link
	input  wire                       pme_msg_valid,
	input  wire [`RPPME_RID_W-1:0]    pme_msg_rid,
	output wire                       pme_msg_ready,
	// Event outputs
	output reg                        serr_pulse,
	output reg                        pme_irq_pulse
);

	reg  [`RPPME_CTRL_W-1:0] ctrl_reg;
	reg  [`RPPME_CTRL_W-1:0] ctrl_next;
	reg                      pme_stat_reg;
	reg  [`RPPME_RID_W-1:0]  rid_reg;
	reg  [`RPPME_RID_W-1:0]  q_mem [0:QDEPTH-1];
	reg  [QPTR_W-1:0]        q_rd_reg;
	reg  [QPTR_W-1:0]        q_wr_reg;
	reg  [QPTR_W:0]          q_cnt_reg;

	wire wr_ctrl = cfg_wr && (cfg_addr == `RPPME_OFF_ROOT_CTRL) && cfg_be[`RPPME_BE_CTRL];
	wire wr_stat = cfg_wr && (cfg_addr == `RPPME_OFF_ROOT_STAT) && cfg_be[`RPPME_BE_STAT];
	wire stat_w1c = wr_stat && cfg_wdata[`RPPME_BIT_PME_STAT];
	wire q_full  = (q_cnt_reg == QDEPTH[QPTR_W:0]);
	wire q_empty = (q_cnt_reg == {(QPTR_W+1){1'b0}});
	wire pme_in  = pme_msg_valid && pme_msg_ready;

	assign pme_msg_ready = !q_full;

	wire stat_free = !pme_stat_reg || stat_w1c;
	wire deliver_q = stat_free && !q_empty;
	wire direct  = stat_free && q_empty && pme_in;
	wire push    = pme_in && !direct;
	wire deliver = deliver_q || direct;
	wire pend_flag = !q_empty;

	wire [`RPPME_ERR_N-1:0] loc_err_vec = {loc_err_fatal, loc_err_nonfatal, loc_err_corr};
	wire [`RPPME_ERR_N-1:0] msg_err_vec = {msg_err_fatal, msg_err_nonfatal, msg_err_corr};
	wire [`RPPME_ERR_N-1:0] class_hit;

	genvar gi;
	generate
		for (gi = 0; gi < `RPPME_ERR_N; gi = gi + 1)
		begin : g_class
			assign class_hit[gi] = ctrl_reg[gi] && (loc_err_vec[gi] || msg_err_vec[gi]);
		end
	endgenerate

	always @*
	begin
		ctrl_next = ctrl_reg;
		if (wr_ctrl)
		begin
			ctrl_next = cfg_wdata[`RPPME_CTRL_W-1:0];
		end
	end

	// Control register
	always @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			ctrl_reg <= `RPPME_CTRL_RST;
		end
		else
		begin
			ctrl_reg <= ctrl_next;
		end
	end

	always @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			pme_stat_reg <= 1'b0;
		end
		else if (deliver)
		begin
			pme_stat_reg <= 1'b1;
		end
		else if (stat_w1c)
		begin
			pme_stat_reg <= 1'b0;
		end
	end

	always @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			rid_reg <= `RPPME_RID_RST;
		end
		else if (direct)
		begin
			rid_reg <= pme_msg_rid;
		end
		else if (deliver_q)
		begin
			rid_reg <= q_mem[q_rd_reg];
		end
	end

	always @(posedge clk_sys)
	begin
		if (push)
		begin
			q_mem[q_wr_reg] <= pme_msg_rid;
		end
	end

	always @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			q_rd_reg  <= {QPTR_W{1'b0}};
			q_wr_reg  <= {QPTR_W{1'b0}};
			q_cnt_reg <= {(QPTR_W+1){1'b0}};
		end
		else
		begin
			if (push)
			begin
				q_wr_reg <= q_wr_reg + 1'b1;
			end
			if (deliver_q)
			begin
				q_rd_reg <= q_rd_reg + 1'b1;
			end
			if (push && !deliver_q)
			begin
				q_cnt_reg <= q_cnt_reg + 1'b1;
			end
			else if (deliver_q && !push)
			begin
				q_cnt_reg <= q_cnt_reg - 1'b1;
			end
		end
	end

	always @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			pme_irq_pulse <= 1'b0;
		end
		else
		begin
			pme_irq_pulse <= ctrl_next[`RPPME_BIT_PME_IE]
				&& (deliver || (!ctrl_reg[`RPPME_BIT_PME_IE] && pme_stat_reg));
		end
	end

	always @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			serr_pulse <= 1'b0;
		end
		else
		begin
			serr_pulse <= |class_hit;
		end
	end

	// Read data, unmapped reads zero
	always @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			cfg_rdata <= `RPPME_RDATA_IDLE;
		end
		else if (cfg_rd)
		begin
			if (cfg_addr == `RPPME_OFF_ROOT_CTRL)
			begin
				cfg_rdata <= {28'h0000000, ctrl_reg};
			end
			else if (cfg_addr == `RPPME_OFF_ROOT_STAT)
			begin
				cfg_rdata <= {14'h0000, pend_flag, pme_stat_reg, rid_reg};
			end
			else
			begin
				cfg_rdata <= `RPPME_RDATA_IDLE;
			end
		end
	end

endmodule // rppme_root_port_events

// ==== dv/rppme_chk_sva.sv ====
// Checker for event reporting
`timescale 1ns/1ps
module rppme_chk (
	input logic clk_sys, rst_n, cfg_rd, cfg_wr, cmd_serr_en, pme_msg_ready, serr_pulse,
	input logic pme_irq_pulse, loc_err_fatal, loc_err_nonfatal, loc_err_corr, msg_err_fatal,
	input logic msg_err_nonfatal, msg_err_corr, input logic [3:0] cfg_be,
	input logic [11:0] cfg_addr, input logic [31:0] cfg_wdata, cfg_rdata);
	logic [3:0] ctl_reg;
	wire err = |({loc_err_fatal | msg_err_fatal, loc_err_nonfatal | msg_err_nonfatal,
		loc_err_corr | msg_err_corr} & ctl_reg[2:0]);
	always @(posedge clk_sys)
		if (!rst_n) ctl_reg <= 4'h0;
		else if (cfg_wr && cfg_addr == 12'h0BC && cfg_be[0]) ctl_reg <= cfg_wdata[3:0];
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	sequence rd_s(a); cfg_rd && cfg_addr == a; endsequence
	serr_on_a: assert property (err |=> serr_pulse) else $error("serr lost");
	serr_off_a: assert property (!err |=> !serr_pulse) else $error("serr extra");
	serr_cmd_a: assert property (err && !cmd_serr_en |=> serr_pulse) else $error("cmd");
	irq_gate_a: assert property (pme_irq_pulse |-> ctl_reg[3]) else $error("irq");
	rd_ctl_a: assert property (rd_s(12'h0BC) |=> cfg_rdata == {28'h0, $past(ctl_reg)})
		else $error("ctl read");
	rd_stat_a: assert property (rd_s(12'h0C0) |=> cfg_rdata[31:18] == 14'h0) else $error("rsvd");
	rd_none_a: assert property (rd_s(12'h0F0) |=> cfg_rdata == 32'h0) else $error("unmapped");
	rdy_rst_a: assert property ($rose(rst_n) |-> pme_msg_ready) else $error("ready");
endmodule // rppme_chk
bind rppme_root_port_events rppme_chk rppme_chk_i (.*);

// ==== dv/rppme_pme_src.sv ====
// Far-side model offering PME messages
`timescale 1ns/1ps
module rppme_pme_src (
	input wire logic clk_sys, pme_msg_ready,
	output logic pme_msg_valid = 1'b0,
	output logic [15:0] pme_msg_rid = 16'h0000);
	task send(input logic [15:0] rid);
		@(negedge clk_sys);
		pme_msg_valid = 1'b1;
		pme_msg_rid = rid;
		do @(posedge clk_sys); while (!pme_msg_ready);
		@(negedge clk_sys);
		pme_msg_valid = 1'b0;
		pme_msg_rid = ~rid;
	endtask
endmodule // rppme_pme_src

// ==== dv/testbench.sv ====
// Bench for event reporting
`timescale 1ns/1ps
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin error_cnt++; \
	$display("MISMATCH %s exp %h got %h", n, e, s); end end
module testbench;
	logic clk_sys = 0, rst_n = 0, cfg_wr = 0, cfg_rd = 0, cmd_serr_en = 1;
	logic pme_msg_valid, pme_msg_ready, serr_pulse, pme_irq_pulse;
	logic [11:0] cfg_addr = 0;
	logic [3:0] cfg_be = 4'hF;
	logic [31:0] cfg_wdata = 0, cfg_rdata;
	logic [15:0] pme_msg_rid;
	logic [2:0] le = 0, me = 0;
	int error_cnt, samples_checked, irq_n;
	rppme_root_port_events rppme_root_port_events_i (.*, .loc_err_fatal(le[2]),
		.loc_err_nonfatal(le[1]), .loc_err_corr(le[0]), .msg_err_fatal(me[2]),
		.msg_err_nonfatal(me[1]), .msg_err_corr(me[0]));
	rppme_pme_src rppme_pme_src_i (.*);
	initial forever #12.5 clk_sys = ~clk_sys;
	always @(negedge clk_sys) if (pme_irq_pulse) irq_n++;
	task tally_and_finish;
		$display("checked %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		@(negedge clk_sys);
		{cfg_wr, cfg_addr, cfg_wdata} = {1'b1, a, d};
		@(negedge clk_sys);
		cfg_wr = 0;
	endtask
	task rd(input logic [11:0] a, input logic [31:0] e);
		@(negedge clk_sys);
		{cfg_rd, cfg_addr} = {1'b1, a};
		@(negedge clk_sys);
		cfg_rd = 0;
		`CHK("rdata", e, cfg_rdata)
	endtask
	task err(input logic [2:0] l, m, input logic e);
		@(negedge clk_sys);
		{le, me} = {l, m};
		@(negedge clk_sys);
		{le, me} = 6'h00;
		`CHK("serr", e, serr_pulse)
	endtask
	task t_serr;
		for (int k = 0; k < 3; k++) begin
			wr(12'h0BC, 32'h1 << k);
			err(3'h1 << k, 3'h0, 1'b1);
			err(3'h0, 3'h1 << k, 1'b1);
			err(~(3'h1 << k), ~(3'h1 << k), 1'b0);
			cmd_serr_en = ~cmd_serr_en;
		end
	endtask
	task t_pme;
		wr(12'h0BC, 32'h0);
		rppme_pme_src_i.send(16'hA1A1);
		rppme_pme_src_i.send(16'hB2B2);
		rppme_pme_src_i.send(16'hC3C3);
		rd(12'h0C0, 32'h0003A1A1);
		wr(12'h0C0, 32'h0002FFFF);
		rd(12'h0C0, 32'h0003A1A1);
		wr(12'h0C0, 32'h00010000);
		rd(12'h0C0, 32'h0003B2B2);
		wr(12'h0BC, 32'h8);
		wr(12'h0C0, 32'h00010000);
		rd(12'h0C0, 32'h0001C3C3);
		`CHK("irq", 2, irq_n)
		rd(12'h0F0, 32'h0);
	endtask
	task t_queue;
		logic [15:0] r;
		wr(12'h0C0, 32'h00010000);
		rd(12'h0C0, 32'h0000C3C3);
		r = 16'h1111;
		repeat (5)
		begin
			rppme_pme_src_i.send(r);
			r = r + 16'h1111;
		end
		`CHK("ready", 1'b0, pme_msg_ready)
		cfg_be = 4'hB;
		wr(12'h0C0, 32'h00010000);
		cfg_be = 4'hE;
		wr(12'h0BC, 32'h0);
		cfg_be = 4'hF;
		rd(12'h0C0, 32'h00031111);
		rd(12'h0BC, 32'h8);
		r = 16'h1111;
		repeat (4)
		begin
			r = r + 16'h1111;
			wr(12'h0C0, 32'h00010000);
			rd(12'h0C0, {14'h0000, r != 16'h5555, 1'b1, r});
		end
		`CHK("ready", 1'b1, pme_msg_ready)
		`CHK("irq", 7, irq_n)
	endtask
	task t_reset;
		@(negedge clk_sys);
		rst_n = 0;
		repeat (2) @(negedge clk_sys);
		rst_n = 1;
		rd(12'h0BC, 32'h0);
		rd(12'h0C0, 32'h0);
		`CHK("ready", 1'b1, pme_msg_ready)
	endtask
	initial begin
		repeat (10) @(negedge clk_sys);
		rst_n = 1;
		t_serr;
		t_pme;
		t_queue;
		t_reset;
		tally_and_finish;
	end
	initial begin
		#20000;
		error_cnt++;
		tally_and_finish;
	end
endmodule // testbench
